/* File: rtl/seq_pkg.sv */
// Shared types and constants for the instruction sequencer
package seq_pkg;
   // ==========================================================
   // Basic types
   typedef logic [14:0] word_t;
   typedef logic [11:0] addr_t;
   typedef logic [3:0]  pulse_t;
   typedef logic [3:0]  ord_t;
   typedef logic [1:0]  ctr_t;
   typedef logic [13:0] mag_t;

   // ==========================================================
   // Memory cycle framing
   localparam pulse_t FIRST_PULSE  = 4'h1;
   localparam pulse_t LAST_PULSE   = 4'hC;
   localparam pulse_t READ_PULSE   = 4'h1;
   localparam pulse_t SENSE_PULSE  = 4'h7;
   localparam pulse_t COMMIT_PULSE = 4'hA;

   // ==========================================================
   // Address map
   localparam addr_t ACC_ADDR    = 12'h000;
   localparam addr_t LINK_ADDR   = 12'h001;
   localparam addr_t LOW_ADDR    = 12'h002;
   localparam addr_t ERASE_BASE  = 12'h003;
   localparam addr_t RESUME_ADDR = 12'h00F;
   localparam addr_t FIXED_BASE  = 12'h400;
   localparam addr_t START_ADDR  = 12'h800;
   localparam addr_t PC_STEP     = 12'h001;

   // ==========================================================
   // Order codes
   localparam ord_t ORD_TC     = 4'h0;
   localparam ord_t ORD_CCS    = 4'h1;
   localparam ord_t ORD_INDEX  = 4'h2;
   localparam ord_t ORD_XCH    = 4'h3;
   localparam ord_t ORD_CS     = 4'h4;
   localparam ord_t ORD_TS     = 4'h5;
   localparam ord_t ORD_AD     = 4'h6;
   localparam ord_t ORD_MASK   = 4'h7;
   localparam ord_t ORD_MP     = 4'h8;
   localparam ord_t ORD_DV     = 4'h9;
   localparam ord_t ORD_SU     = 4'hA;
   localparam ord_t ORD_RESUME = 4'hE;
   localparam ord_t ORD_RUPT   = 4'hF;

   // ==========================================================
   // Counter commands
   localparam ctr_t CTR_INC       = 2'h0;
   localparam ctr_t CTR_DEC       = 2'h1;
   localparam ctr_t CTR_SHIFT     = 2'h2;
   localparam ctr_t CTR_SHIFT_ONE = 2'h3;

   // ==========================================================
   // Ones' complement words
   localparam word_t POS_ZERO     = 15'h0000;
   localparam word_t POS_ONE      = 15'h0001;
   localparam word_t NEG_ONE      = 15'h7FFE;
   localparam word_t NEG_ZERO     = 15'h7FFF;
   localparam mag_t  MAG_ONE      = 14'h0001;
   localparam mag_t  MAG_ALL_ONES = 14'h3FFF;

   // ==========================================================
   // Sequencer types
   typedef enum logic [2:0] {SUB_FETCH, SUB_EXEC, SUB_RUPT, SUB_RESUME, SUB_CTR} sub_e;

   typedef struct packed {
      logic  read;
      logic  write;
      addr_t addr;
      word_t wdata;
   } mem_req_s;

   typedef struct packed {
      logic  valid;
      ctr_t  kind;
      addr_t addr;
   } ctr_cmd_s;

   typedef struct packed {
      logic  valid;
      addr_t addr;
   } rupt_req_s;

   typedef struct packed {
      sub_e  sub;
      sub_e  ret_sub;
      ord_t  op;
      addr_t ea;
      word_t operand;
      word_t acc;
      word_t link;
      word_t low;
      addr_t pc;
      word_t idx;
      logic  idx_pend;
      logic  in_rupt;
      logic  resume_seen;
      addr_t save_pc;
      word_t save_acc;
      ctr_t  ctr_kind;
      addr_t ctr_addr;
   } seq_state_s;
endpackage : seq_pkg

/* File: rtl/pulse_timer.sv */
// Twelve-pulse memory cycle timer
`timescale 1ns/1ps
module pulse_timer
   import seq_pkg::*;
(
   input  wire logic clock,
   input  wire logic arst_n,
   output pulse_t    pulse,
   output logic      first_cycle_pulse,
   output logic      last_cycle_pulse
);
   typedef struct packed {
      pulse_t count;
   } timer_state_s;

   timer_state_s s;
   timer_state_s n;

   // ==========================================================
   // Pulse counter
   always_comb begin
      n = s;
      n.count = (s.count == LAST_PULSE) ? FIRST_PULSE : s.count + FIRST_PULSE;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s.count <= FIRST_PULSE;
      end else begin
         s <= n;
      end
   end

   assign pulse             = s.count;
   assign first_cycle_pulse = (s.count == FIRST_PULSE);
   assign last_cycle_pulse  = (s.count == LAST_PULSE);

   // ==========================================================
   // Checks
   sequence s_frame;
      first_cycle_pulse ##11 last_cycle_pulse;
   endsequence

   property p_frame;
      @(posedge clock) disable iff (!arst_n)
         first_cycle_pulse |-> s_frame;
   endproperty
   a_frame: assert property (p_frame) else $error("cycle not twelve pulses");

   property p_wrap;
      @(posedge clock) disable iff (!arst_n)
         last_cycle_pulse |=> first_cycle_pulse && !last_cycle_pulse;
   endproperty
   a_wrap: assert property (p_wrap) else $error("cycle did not restart");
endmodule : pulse_timer

/* File: rtl/ones_adder.sv */
// Ones' complement adder with end-around carry
`timescale 1ns/1ps
module ones_adder
   import seq_pkg::*;
(
   input  word_t a,
   input  word_t b,
   output word_t sum
);
   logic [15:0] raw;

   assign raw = {1'b0, a} + {1'b0, b};
   assign sum = raw[14:0] + {14'h0000, raw[15]};
endmodule : ones_adder

/* File: rtl/instruction_sequencer.sv */
// Instruction sequencer: fetch, decode and execution per memory cycle
`timescale 1ns/1ps
module instruction_sequencer
   import seq_pkg::*;
(
   input  wire logic clock,
   input  wire logic arst_n,
   input  word_t     mem_rdata,
   output mem_req_s  mem_req,
   input  ctr_cmd_s  ctr_cmd,
   output logic      ctr_ack,
   input  rupt_req_s rupt_req,
   output logic      rupt_ack,
   output ord_t      order_code,
   output sub_e      sub_code,
   output word_t     acc,
   output logic      in_rupt,
   output logic      first_cycle_pulse,
   output logic      last_cycle_pulse
);
   seq_state_s  s;
   seq_state_s  next_s;
   pulse_t      pulse;
   logic        sense;
   logic        commit;
   logic        uses_operand;
   logic        is_fetch;
   logic        store_en;
   logic        exec_commit;
   addr_t       cyc_addr;
   word_t       reg_read;
   word_t       fetched;
   logic [15:0] widened;
   ord_t        dec_op;
   addr_t       dec_ea;
   word_t       addend;
   word_t       ctr_inc;
   word_t       sum_acc;
   word_t       sum_ctr;
   word_t       ctr_result;
   word_t       store_val;
   mag_t        mag_acc;
   mag_t        mag_op;
   logic [27:0] product;
   logic        sign_neg;
   word_t       mp_hi;
   word_t       mp_lo;
   mag_t        quot;
   mag_t        rem;
   addr_t       ccs_skip;
   sub_e        follow;

   function automatic logic is_reg(input addr_t a);
      is_reg = (a < ERASE_BASE);
   endfunction : is_reg

   function automatic logic is_fixed(input addr_t a);
      is_fixed = (a >= FIXED_BASE);
   endfunction : is_fixed

   pulse_timer u_timer (
      .clock             (clock),
      .arst_n            (arst_n),
      .pulse             (pulse),
      .first_cycle_pulse (first_cycle_pulse),
      .last_cycle_pulse  (last_cycle_pulse)
   );

   ones_adder u_acc_add (
      .a   (s.acc),
      .b   (addend),
      .sum (sum_acc)
   );

   ones_adder u_ctr_add (
      .a   (s.operand),
      .b   (ctr_inc),
      .sum (sum_ctr)
   );

   // ==========================================================
   // Cycle decode
   assign sense        = (pulse == SENSE_PULSE);
   assign commit       = (pulse == COMMIT_PULSE);
   assign is_fetch     = (s.sub == SUB_FETCH);
   assign uses_operand = (s.sub == SUB_CTR) ||
                         (s.sub == SUB_EXEC && s.op != ORD_TC && s.op <= ORD_SU);
   assign cyc_addr     = is_fetch ? s.pc : (s.sub == SUB_CTR) ? s.ctr_addr : s.ea;
   assign exec_commit  = commit && s.sub == SUB_EXEC;

   always_comb begin
      case (cyc_addr)
         ACC_ADDR:  reg_read = s.acc;
         LINK_ADDR: reg_read = s.link;
         default:   reg_read = s.low;
      endcase
   end

   // Instruction word widened by any pending index quantity
   assign fetched = is_reg(s.pc) ? s.acc : mem_rdata;
   assign widened = {1'b0, fetched} + (s.idx_pend ? {1'b0, s.idx} : 16'h0000);
   assign dec_op  = widened[15:12];
   assign dec_ea  = widened[15] ? fetched[11:0] : widened[11:0];

   // ==========================================================
   // Arithmetic
   assign addend   = (s.op == ORD_SU) ? ~s.operand : s.operand;
   assign ctr_inc  = (s.ctr_kind == CTR_DEC) ? NEG_ONE : POS_ONE;
   assign mag_acc  = s.acc[14] ? ~s.acc[13:0] : s.acc[13:0];
   assign mag_op   = s.operand[14] ? ~s.operand[13:0] : s.operand[13:0];
   assign product  = mag_acc * mag_op;
   assign sign_neg = s.acc[14] ^ s.operand[14];
   assign mp_hi    = sign_neg ? ~{1'b0, product[27:14]} : {1'b0, product[27:14]};
   assign mp_lo    = sign_neg ? ~{1'b0, product[13:0]} : {1'b0, product[13:0]};
   assign quot     = (mag_op == 14'h0000) ? MAG_ALL_ONES : mag_acc / mag_op;
   assign rem      = (mag_op == 14'h0000) ? mag_acc : mag_acc % mag_op;
   assign ccs_skip = {10'h000, s.operand[14], (mag_op == 14'h0000)};

   always_comb begin
      case (s.ctr_kind)
         CTR_SHIFT:     ctr_result = {s.operand[13:0], 1'b0};
         CTR_SHIFT_ONE: ctr_result = {s.operand[13:0], 1'b1};
         default:       ctr_result = sum_ctr;
      endcase
   end

   assign store_en  = (s.sub == SUB_CTR) ||
                      (s.sub == SUB_EXEC && (s.op == ORD_XCH || s.op == ORD_TS));
   assign store_val = (s.sub == SUB_CTR) ? ctr_result :
                      store_en ? s.acc : s.operand;

   // ==========================================================
   // Memory strobes; erasable words are rewritten after readout
   assign mem_req.read  = (pulse == READ_PULSE) && (is_fetch || uses_operand) &&
                          !is_reg(cyc_addr);
   assign mem_req.write = commit && (is_fetch || uses_operand) &&
                          !is_reg(cyc_addr) && !is_fixed(cyc_addr);
   assign mem_req.addr  = cyc_addr;
   assign mem_req.wdata = store_val;

   // ==========================================================
   // Successor subinstruction
   always_comb begin
      case (s.sub)
         SUB_FETCH: follow = s.resume_seen ? SUB_RESUME : SUB_EXEC;
         SUB_CTR:   follow = s.ret_sub;
         default:   follow = (rupt_req.valid && !s.in_rupt && !s.idx_pend) ?
                             SUB_RUPT : SUB_FETCH;
      endcase
   end

   assign ctr_ack  = last_cycle_pulse && ctr_cmd.valid;
   assign rupt_ack = commit && s.sub == SUB_RUPT;

   // ==========================================================
   // State update
   always_comb begin
      next_s = s;
      if (sense && (is_fetch || uses_operand)) begin
         next_s.operand = is_reg(cyc_addr) ? reg_read : mem_rdata;
      end
      if (sense && is_fetch) begin
         next_s.op          = dec_op;
         next_s.ea          = dec_ea;
         next_s.resume_seen = s.in_rupt && dec_op == ORD_TC && dec_ea == RESUME_ADDR;
      end
      if (commit && store_en && is_reg(cyc_addr)) begin
         case (cyc_addr)
            ACC_ADDR:  next_s.acc  = store_val;
            LINK_ADDR: next_s.link = store_val;
            default:   next_s.low  = store_val;
         endcase
      end
      if (commit) begin
         case (s.sub)
            SUB_FETCH: begin
               next_s.pc       = s.pc + PC_STEP;
               next_s.idx_pend = 1'b0;
            end
            SUB_EXEC: begin
               case (s.op)
                  ORD_TC: begin
                     next_s.link = {3'h0, s.pc};
                     next_s.pc   = s.ea;
                  end
                  ORD_CCS: begin
                     next_s.acc = (mag_op == 14'h0000) ? POS_ZERO : {1'b0, mag_op - MAG_ONE};
                     next_s.pc  = s.pc + ccs_skip;
                  end
                  ORD_INDEX: begin
                     next_s.idx      = s.operand;
                     next_s.idx_pend = 1'b1;
                  end
                  ORD_XCH:  next_s.acc = s.operand;
                  ORD_CS:   next_s.acc = ~s.operand;
                  ORD_AD:   next_s.acc = sum_acc;
                  ORD_MASK: next_s.acc = s.acc & s.operand;
                  ORD_MP: begin
                     next_s.acc = mp_hi;
                     next_s.low = mp_lo;
                  end
                  ORD_DV: begin
                     next_s.acc = sign_neg ? ~{1'b0, quot} : {1'b0, quot};
                     next_s.low = s.acc[14] ? ~{1'b0, rem} : {1'b0, rem};
                  end
                  ORD_SU:   next_s.acc = sum_acc;
                  default:  next_s.acc = s.acc;
               endcase
            end
            SUB_RUPT: begin
               next_s.save_pc  = s.pc;
               next_s.save_acc = s.acc;
               next_s.pc       = rupt_req.addr;
               next_s.in_rupt  = 1'b1;
            end
            SUB_RESUME: begin
               next_s.pc          = s.save_pc;
               next_s.acc         = s.save_acc;
               next_s.in_rupt     = 1'b0;
               next_s.resume_seen = 1'b0;
            end
            default: next_s.ctr_kind = s.ctr_kind;
         endcase
      end
      if (last_cycle_pulse) begin
         next_s.sub = follow;
         if (follow == SUB_RUPT) begin
            next_s.op = ORD_RUPT;
         end else if (follow == SUB_RESUME) begin
            next_s.op = ORD_RESUME;
         end
         if (ctr_cmd.valid) begin
            next_s.sub      = SUB_CTR;
            next_s.ret_sub  = follow;
            next_s.ctr_addr = ctr_cmd.addr;
            next_s.ctr_kind = ctr_cmd.kind;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s             <= '0;
         s.sub         <= SUB_FETCH;
         s.ret_sub     <= SUB_FETCH;
         s.pc          <= START_ADDR;
      end else begin
         s <= next_s;
      end
   end

   assign order_code = s.op;
   assign sub_code   = s.sub;
   assign acc        = s.acc;
   assign in_rupt    = s.in_rupt;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   property p_tc_link;
      exec_commit && s.op == ORD_TC |=> s.pc == $past(s.ea) && s.link == {3'h0, $past(s.pc)};
   endproperty
   a_tc_link: assert property (p_tc_link) else $error("jump did not save link");

   property p_ccs_neg_zero;
      exec_commit && s.op == ORD_CCS && s.operand == NEG_ZERO |=>
         s.pc == $past(s.pc) + 12'h003 && s.acc == POS_ZERO;
   endproperty
   a_ccs_neg_zero: assert property (p_ccs_neg_zero) else $error("bad skip on minus zero");

   property p_index_extra;
      sense && is_fetch && s.idx_pend && widened[15] |=> s.ea == $past(fetched[11:0]);
   endproperty
   a_index_extra: assert property (p_index_extra) else $error("extra code changed address");

   property p_xch_fixed;
      exec_commit && s.op == ORD_XCH && is_fixed(s.ea) |->
         !mem_req.write ##1 s.acc == $past(s.operand);
   endproperty
   a_xch_fixed: assert property (p_xch_fixed) else $error("fixed exchange misbehaved");

   property p_cs;
      exec_commit && s.op == ORD_CS |=> s.acc == ~$past(s.operand);
   endproperty
   a_cs: assert property (p_cs) else $error("complement load wrong");

   property p_su_self;
      exec_commit && s.op == ORD_SU && s.ea == ACC_ADDR |=> s.acc == NEG_ZERO;
   endproperty
   a_su_self: assert property (p_su_self) else $error("self subtract not minus zero");

   property p_rupt_code;
      last_cycle_pulse && follow == SUB_RUPT && !ctr_cmd.valid |=>
         order_code == ORD_RUPT && sub_code == SUB_RUPT;
   endproperty
   a_rupt_code: assert property (p_rupt_code) else $error("interrupt code missing");

   sequence s_resume_fetch;
      last_cycle_pulse && is_fetch && s.resume_seen && !ctr_cmd.valid;
   endsequence

   property p_resume;
      s_resume_fetch |=> s.sub == SUB_RESUME ##10 !s.in_rupt && s.pc == s.save_pc;
   endproperty
   a_resume: assert property (p_resume) else $error("resume not carried out");

   sequence s_ctr_run;
      s.sub == SUB_CTR && first_cycle_pulse ##9 commit && s.sub == SUB_CTR;
   endsequence

   property p_ctr_cycle;
      ctr_ack |=> s_ctr_run;
   endproperty
   a_ctr_cycle: assert property (p_ctr_cycle) else $error("counter cycle not run");

   property p_ctr_shift_one;
      commit && s.sub == SUB_CTR && s.ctr_kind == CTR_SHIFT_ONE && mem_req.write |->
         mem_req.wdata == {s.operand[13:0], 1'b1};
   endproperty
   a_ctr_shift_one: assert property (p_ctr_shift_one) else $error("shift add one wrong");

   property p_rupt_save;
      rupt_ack |=> s.pc == $past(rupt_req.addr) && s.in_rupt && s.save_pc == $past(s.pc);
   endproperty
   a_rupt_save: assert property (p_rupt_save) else $error("interrupt entry wrong");
endmodule : instruction_sequencer

/* File: tb/prio_mem_model.sv */
// Behavioural core memory and priority control facing the sequencer
`timescale 1ns/1ps
module prio_mem_model
   import seq_pkg::*;
(
   input  wire logic clock,
   input  wire logic arst_n,
   input  mem_req_s  mem_req,
   output word_t     mem_rdata,
   output ctr_cmd_s  ctr_cmd,
   input  wire logic ctr_ack,
   output rupt_req_s rupt_req,
   input  wire logic rupt_ack,
   input  wire logic ctr_go,
   input  ctr_t      ctr_kind,
   input  addr_t     ctr_addr,
   input  wire logic rupt_go,
   input  addr_t     rupt_addr
);
   // ==========================================================
   // Core array, destructive readout below fixed area
   word_t mem [0:4095];
   int    held;

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mem_rdata <= POS_ZERO;
         held      <= 6;
      end else begin
         if (held < 6) held <= held + 1;
         // Sense data is gone after the sampling edge
         if (held == 5) mem_rdata <= ~mem_rdata;
         if (mem_req.read) begin
            mem_rdata <= mem[mem_req.addr];
            held      <= 0;
            if (mem_req.addr < FIXED_BASE) mem[mem_req.addr] <= POS_ZERO;
         end
         if (mem_req.write) mem[mem_req.addr] <= mem_req.wdata;
      end
   end

   // ==========================================================
   // Requests held until acknowledged
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctr_cmd  <= '0;
         rupt_req <= '0;
      end else begin
         if (ctr_ack) ctr_cmd.valid <= 1'b0;
         else if (ctr_go) ctr_cmd <= '{1'b1, ctr_kind, ctr_addr};
         if (rupt_ack) rupt_req.valid <= 1'b0;
         else if (rupt_go) rupt_req <= '{1'b1, rupt_addr};
      end
   end
endmodule : prio_mem_model

/* File: tb/test_guidance_computer_instruction_set.sv */
// Self-checking bench for the instruction sequencer
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
   $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_guidance_computer_instruction_set
   import seq_pkg::*;
();
   localparam int DLY   = 2;
   localparam int LIMIT = 20000;

   logic      clock;
   logic      arst_n;
   word_t     mem_rdata;
   mem_req_s  mem_req;
   ctr_cmd_s  ctr_cmd;
   logic      ctr_ack;
   rupt_req_s rupt_req;
   logic      rupt_ack;
   ord_t      order_code;
   sub_e      sub_code;
   word_t     acc;
   logic      in_rupt;
   logic      first_cycle_pulse;
   logic      last_cycle_pulse;
   logic      ctr_go;
   ctr_t      ctr_kind;
   addr_t     ctr_addr;
   logic      rupt_go;
   addr_t     rupt_addr;
   int        err_count;
   int        tests_run;
   int        cycles;

   // ==========================================================
   // Memory image and checkpoints: address, word
   logic [26:0] img [42] = '{
      {12'h800,15'h4010}, {12'h801,15'h4000}, {12'h802,15'h6011}, {12'h803,15'h6000},
      {12'h804,15'h5012}, {12'h805,15'h3500}, {12'h806,15'h3010}, {12'h807,15'h2013},
      {12'h808,15'h7011}, {12'h809,15'h3002}, {12'h80A,15'h2014}, {12'h80B,15'h7010},
      {12'h80C,15'h2014}, {12'h80D,15'h7000}, {12'h80E,15'h4016}, {12'h80F,15'h2015},
      {12'h810,15'h7011}, {12'h811,15'h3002}, {12'h812,15'h7012}, {12'h813,15'h1017},
      {12'h817,15'h1011}, {12'h818,15'h101A}, {12'h81B,15'h101B}, {12'h81D,15'h0830},
      {12'h830,15'h3001}, {12'h831,15'h0831}, {12'h840,15'h4000}, {12'h841,15'h000F},
      {12'h010,15'h0005}, {12'h011,15'h0003}, {12'h013,15'h1000}, {12'h014,15'h3000},
      {12'h015,15'h2000}, {12'h016,15'h7FF1}, {12'h017,15'h7FFF}, {12'h01A,15'h7FFC},
      {12'h01B,15'h0000}, {12'h500,15'h0007}, {12'h020,15'h7FFE}, {12'h021,15'h0000},
      {12'h022,15'h1234}, {12'h023,15'h4001}};
   logic [26:0] chk [21] = '{
      {12'h801,15'h7FFA}, {12'h802,15'h0005}, {12'h803,15'h0008}, {12'h804,15'h0010},
      {12'h805,15'h0010}, {12'h806,15'h0007}, {12'h807,15'h0005}, {12'h809,15'h0000},
      {12'h80A,15'h000F}, {12'h80C,15'h0008}, {12'h80E,15'h7FFF}, {12'h80F,15'h000E},
      {12'h811,15'h0004}, {12'h812,15'h0002}, {12'h813,15'h0000}, {12'h817,15'h0000},
      {12'h818,15'h0002}, {12'h81B,15'h0002}, {12'h81D,15'h0000}, {12'h830,15'h0000},
      {12'h831,15'h081E}};
   word_t ctr_exp [4] = '{15'h7FFF, 15'h7FFE, 15'h2468, 15'h0003};

   instruction_sequencer dut_u (
      .clock             (clock),
      .arst_n            (arst_n),
      .mem_rdata         (mem_rdata),
      .mem_req           (mem_req),
      .ctr_cmd           (ctr_cmd),
      .ctr_ack           (ctr_ack),
      .rupt_req          (rupt_req),
      .rupt_ack          (rupt_ack),
      .order_code        (order_code),
      .sub_code          (sub_code),
      .acc               (acc),
      .in_rupt           (in_rupt),
      .first_cycle_pulse (first_cycle_pulse),
      .last_cycle_pulse  (last_cycle_pulse)
   );

   prio_mem_model mem_u (
      .clock     (clock),
      .arst_n    (arst_n),
      .mem_req   (mem_req),
      .mem_rdata (mem_rdata),
      .ctr_cmd   (ctr_cmd),
      .ctr_ack   (ctr_ack),
      .rupt_req  (rupt_req),
      .rupt_ack  (rupt_ack),
      .ctr_go    (ctr_go),
      .ctr_kind  (ctr_kind),
      .ctr_addr  (ctr_addr),
      .rupt_go   (rupt_go),
      .rupt_addr (rupt_addr)
   );

   always #12.5 clock = ~clock;

   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_count++;
         give_verdict();
      end
   end

   // ==========================================================
   // Helpers
   task automatic step();
      @(posedge clock);
      #DLY;
   endtask : step

   task automatic wait_fetch(input addr_t a);
      int n;
      n = 0;
      while (!(mem_req.read === 1'b1 && sub_code === SUB_FETCH && mem_req.addr === a)
             && n < 600) begin
         step();
         n++;
      end
      `CHK(mem_req.addr, a)
   endtask : wait_fetch

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict

   // ==========================================================
   // Scenarios
   task automatic test_framing();
      int n;
      int last_n;
      n = 0;
      last_n = 0;
      while (first_cycle_pulse !== 1'b1 && n < 20) begin
         step();
         n++;
      end
      n = 0;
      do begin
         step();
         n++;
         if (last_cycle_pulse === 1'b1) last_n = n;
      end while (first_cycle_pulse !== 1'b1 && n < 20);
      `CHK(n, 12)
      `CHK(last_n, 11)
      $display("test_framing done");
   endtask : test_framing

   task automatic test_program();
      for (int i = 0; i < 21; i++) begin
         wait_fetch(chk[i][26:15]);
         `CHK(acc, chk[i][14:0])
      end
      `CHK(mem_u.mem[12'h012], 15'h0010)
      `CHK(mem_u.mem[12'h010], 15'h0007)
      `CHK(mem_u.mem[12'h011], 15'h0003)
      $display("test_program done");
   endtask : test_program

   task automatic test_counters();
      int n;
      for (int k = 0; k < 4; k++) begin
         ctr_go = 1'b1;
         ctr_kind = ctr_t'(k);
         ctr_addr = 12'h020 + addr_t'(k);
         step();
         ctr_go = 1'b0;
         n = 0;
         while (ctr_ack !== 1'b1 && n < 30) begin
            step();
            n++;
         end
         `CHK(ctr_ack, 1'b1)
         step();
         `CHK(sub_code, SUB_CTR)
         n = 0;
         while (!(mem_req.write === 1'b1 && mem_req.addr === ctr_addr) && n < 30) begin
            step();
            n++;
         end
         `CHK(mem_req.wdata, ctr_exp[k])
      end
      wait_fetch(12'h831);
      `CHK(acc, 15'h081E)
      $display("test_counters done");
   endtask : test_counters

   task automatic test_rupt();
      int n;
      rupt_go = 1'b1;
      rupt_addr = 12'h840;
      step();
      rupt_go = 1'b0;
      n = 0;
      while (rupt_ack !== 1'b1 && n < 60) begin
         step();
         n++;
      end
      `CHK(rupt_ack, 1'b1)
      `CHK(order_code, ORD_RUPT)
      `CHK(sub_code, SUB_RUPT)
      wait_fetch(12'h840);
      `CHK(in_rupt, 1'b1)
      wait_fetch(12'h841);
      `CHK(acc, 15'h77E1)
      n = 0;
      while (sub_code !== SUB_RESUME && n < 60) begin
         step();
         n++;
      end
      `CHK(order_code, ORD_RESUME)
      wait_fetch(12'h831);
      `CHK(acc, 15'h081E)
      `CHK(in_rupt, 1'b0)
      $display("test_rupt done");
   endtask : test_rupt

   initial begin
      clock = 1'b0;
      arst_n = 1'b0;
      ctr_go = 1'b0;
      ctr_kind = CTR_INC;
      ctr_addr = '0;
      rupt_go = 1'b0;
      rupt_addr = '0;
      err_count = 0;
      tests_run = 0;
      cycles = 0;
      for (int i = 0; i < 42; i++) mem_u.mem[img[i][26:15]] = img[i][14:0];
      repeat (16) @(posedge clock);
      #DLY;
      arst_n = 1'b1;
      test_framing();
      test_program();
      test_counters();
      test_rupt();
      give_verdict();
   end
endmodule : test_guidance_computer_instruction_set
